// File: ncc_pkg.sv
// Constants shared by the primary configuration command block.
`default_nettype none
package ncc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFF_ID = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STICKY = 8'h40;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // Writable command bits: 0,1,2,6,8,10
  localparam logic [15:0] CMD_WMASK = 16'h0547;
  localparam int B_IO = 0;
  localparam int B_MEM = 1;
  localparam int B_MASTER = 2;
  localparam int B_PERR = 6;
  localparam int B_SERR = 8;
  localparam int B_INTX_DIS = 10;
  localparam int B_INT_STAT = 19;
  localparam int B_MDPE = 24;
  // Arbitrary identity values, not tied to any real part
  localparam logic [15:0] MAKER_DEFAULT = 16'h1ABC;
  localparam logic [15:0] PART_DEFAULT = 16'h0123;
  localparam logic [31:0] STICKY_RESET = 32'h0000_0000;
  // ****************************************************************
  // Access kinds
  // ****************************************************************
  typedef enum logic [2:0] {ACC_RO, ACC_ROS, ACC_RW, ACC_RWC, ACC_RWS, ACC_RWCS} ncc_access_type;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} ncc_state_type;
endpackage : ncc_pkg
`default_nettype wire

// File: ncc_field.sv
// One 32-bit register word whose bits follow a chosen access kind.
`default_nettype none
module ncc_field #(
  parameter ncc_pkg::ncc_access_type KIND = ncc_pkg::ACC_RW,
  parameter logic [31:0] INIT = 32'h0000_0000
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sticky_reset,
  input wire logic wr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] mask,
  input wire logic [31:0] hw_set,
  output logic [31:0] value
);
  import ncc_pkg::*;
  typedef struct packed {logic [31:0] val;} ncc_field_type;
  ncc_field_type s, next_s;
  logic sticky;
  assign sticky = (KIND == ACC_ROS) || (KIND == ACC_RWS) || (KIND == ACC_RWCS);
  // Per-kind next value; hardware set wins over a write-one clear
  always_comb begin
    next_s = s;
    case (KIND)
      ACC_RW, ACC_RWS: if (wr) next_s.val = (s.val & ~mask) | (wdata & mask);
      ACC_RWC, ACC_RWCS: if (wr) next_s.val = s.val & ~(wdata & mask);
      default: next_s = s;
    endcase
    next_s.val = next_s.val | hw_set;
  end
  // Sticky kinds survive the ordinary reset, only sticky_reset clears them
  always_ff @(posedge ref_clk) begin
    if ((reset && !sticky) || sticky_reset) s.val <= INIT;
    else s <= next_s;
  end
  assign value = s.val;
endmodule : ncc_field
`default_nettype wire

// File: ncc_command.sv
// Primary configuration command block of the non-transparent bridge.
// How it works
// (R1) Six access kinds exist: read-only, read-only sticky, read/write, write-one-clear, and their sticky forms.
// (R2) Dword 0 bits 15:0 return a fixed maker code.
// (R3) Dword 0 bits 31:16 return a fixed part code.
// (R4) Command bit 0 gates I/O response on the primary and resets to zero.
// (R5) Command bit 1 gates memory response on the primary and resets to zero.
// (R6) Command bit 2 gates mastering on the primary and response on the secondary.
// (R7) A reverse bridge with a PCI-X primary may start split completions even with mastering off.
// (R8) Command bit 3 reads zero; special cycles are never claimed.
// (R9) Command bit 4 reads zero; no own memory-write-and-invalidate is issued.
// (R10) Command bit 5 reads zero; palette snoops are ignored.
// (R11) Command bit 6 lets parity errors and poisoned packets set the master data parity status bit.
// (R12) Command bit 7 reads zero; no wait cycle control.
// (R13) Command bit 8 enables error messages forward and SERR_L reverse.
// (R14) Command bit 9 reads zero; no fast back-to-back.
// (R15) Command bit 10 blocks INTx messages and releases any asserted INTx.
// (R16) Status bit 19 reads one while an INTx request is pending; here it reads zero while command bit 10 is set.
// (R17) Writes to read-only and reserved command bits are dropped and read zero.
`default_nettype none
module ncc_command #(
  parameter logic [15:0] MAKER_CODE = ncc_pkg::MAKER_DEFAULT,
  parameter logic [15:0] PART_CODE = ncc_pkg::PART_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sticky_reset,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire logic reverse_mode,
  input wire logic pcix_primary,
  input wire logic intx_request,
  input wire logic parity_event,
  input wire logic fatal_event,
  input wire logic split_completion_req,
  output logic io_enable,
  output logic mem_enable,
  output logic master_enable,
  output logic split_allowed,
  output logic err_message,
  output logic serr_n_out,
  output logic serr_n_oe,
  output logic intx_assert,
  output logic parity_flagged
);
  import ncc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ncc_state_type st;
    logic [15:0] cmd;
    logic mdpe;
    logic [31:0] rdata;
    logic err_msg;
    logic serr;
  } ncc_regs_type;
  ncc_regs_type r, next_r;
  logic [31:0] sticky_val;
  logic sticky_wr;

  // Byte-enable expansion used for every write path
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  // Spare sticky register exercising the sticky write-one-clear kind
  assign sticky_wr = (r.st == ST_WRITE) && (cfg_addr == OFF_STICKY);
  ncc_field #(.KIND(ACC_RWCS), .INIT(STICKY_RESET)) u_sticky ( // [R1]
    .ref_clk(ref_clk),
    .reset(reset),
    .sticky_reset(sticky_reset),
    .wr(sticky_wr),
    .wdata(cfg_wdata),
    .mask(be_mask(cfg_be)),
    .hw_set({31'h0000_0000, r.mdpe}),
    .value(sticky_val)
  );

  // ****************************************************************
  // Configuration access and command logic
  // ****************************************************************
  always_comb begin
    logic [31:0] wm;
    wm = be_mask(cfg_be);
    next_r = r;
    next_r.err_msg = 1'b0;
    case (r.st)
      ST_IDLE: begin
        if (cfg_wr) next_r.st = ST_WRITE;
        else if (cfg_rd) next_r.st = ST_READ;
      end
      ST_READ: begin
        next_r.st = ST_IDLE;
        case (cfg_addr)
          OFF_ID: next_r.rdata = {PART_CODE, MAKER_CODE}; // [R2] [R3]
          OFF_CMD: begin
            // Read-only and reserved command bits read zero
            next_r.rdata = {7'h00, r.mdpe, 4'h0, intx_request & ~r.cmd[B_INTX_DIS], 3'h0, r.cmd & CMD_WMASK}; // [R16] [R17]
          end
          OFF_STICKY: next_r.rdata = sticky_val;
          default: next_r.rdata = 32'h0000_0000;
        endcase
      end
      ST_WRITE: begin
        next_r.st = ST_IDLE;
        if (cfg_addr == OFF_CMD) begin
          // Only command bits 0,1,2,6,8,10 take writes; status bit 24 clears on a written one [R4] [R5] [R6] [R11] [R13] [R15] [R17]
          next_r.cmd = (r.cmd & ~(CMD_WMASK & wm[15:0])) | (cfg_wdata[15:0] & CMD_WMASK & wm[15:0]); // [R8] [R9] [R10] [R12] [R14]
          if (wm[B_MDPE] && cfg_wdata[B_MDPE]) next_r.mdpe = 1'b0;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
    // Parity status is set only when enabled; set wins over clear
    if (parity_event && r.cmd[B_PERR]) next_r.mdpe = 1'b1; // [R11]
    // Forward mode emits an error message pulse, reverse drives SERR_L
    if (fatal_event && r.cmd[B_SERR] && !reverse_mode) next_r.err_msg = 1'b1; // [R13]
    next_r.serr = fatal_event && r.cmd[B_SERR] && reverse_mode; // [R13]
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r.st <= ST_IDLE;
      r.cmd <= CMD_RESET;
      r.mdpe <= 1'b0;
      r.rdata <= 32'h0000_0000;
      r.err_msg <= 1'b0;
      r.serr <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cfg_rdata = r.rdata;
  assign cfg_ack = (r.st != ST_IDLE);
  assign io_enable = r.cmd[B_IO]; // [R4]
  assign mem_enable = r.cmd[B_MEM]; // [R5]
  assign master_enable = r.cmd[B_MASTER]; // [R6]
  // Split completions bypass mastering gate only on a PCI-X reverse primary
  assign split_allowed = split_completion_req && (r.cmd[B_MASTER] || (reverse_mode && pcix_primary)); // [R7]
  assign err_message = r.err_msg;
  assign serr_n_out = 1'b0; // Open drain: only ever pulls low
  assign serr_n_oe = r.serr;
  assign intx_assert = intx_request && !r.cmd[B_INTX_DIS]; // [R15]
  assign parity_flagged = r.mdpe;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_id_fixed: assert property (@(posedge ref_clk) disable iff (reset) // [R2]
    (r.st == ST_READ && cfg_addr == OFF_ID) |=> cfg_rdata == {PART_CODE, MAKER_CODE})
    else $error("identity word wrong");
  a_ro_zero: assert property (@(posedge ref_clk) disable iff (reset) // [R17]
    (r.cmd & ~CMD_WMASK) == 16'h0000) else $error("read-only command bit set");
  a_io_write: assert property (@(posedge ref_clk) disable iff (reset) // [R4]
    (r.st == ST_WRITE && cfg_addr == OFF_CMD && cfg_be[0]) |=> io_enable == $past(cfg_wdata[B_IO]))
    else $error("io enable not written");
  a_mem_write: assert property (@(posedge ref_clk) disable iff (reset) // [R5]
    (r.st == ST_WRITE && cfg_addr == OFF_CMD && cfg_be[0]) |=> mem_enable == $past(cfg_wdata[B_MEM]))
    else $error("mem enable not written");
  a_split_gate: assert property (@(posedge ref_clk) disable iff (reset) // [R7]
    (split_allowed && !master_enable) |-> (reverse_mode && pcix_primary)) else $error("split without rights");
  a_parity_set: assert property (@(posedge ref_clk) disable iff (reset) // [R11]
    (parity_event && r.cmd[B_PERR]) |=> parity_flagged) else $error("parity not flagged");
  a_parity_hold: assert property (@(posedge ref_clk) disable iff (reset) // [R11]
    $rose(parity_flagged) |-> $past(parity_event && r.cmd[B_PERR])) else $error("parity set without cause");
  a_serr_gate: assert property (@(posedge ref_clk) disable iff (reset) // [R13]
    (serr_n_oe || err_message) |-> $past(r.cmd[B_SERR] && fatal_event)) else $error("error report while disabled");
  a_intx_off: assert property (@(posedge ref_clk) disable iff (reset) // [R15]
    r.cmd[B_INTX_DIS] |-> !intx_assert) else $error("intx while disabled");
  a_int_status: assert property (@(posedge ref_clk) disable iff (reset) // [R16]
    (r.st == ST_READ && cfg_addr == OFF_CMD) |=> cfg_rdata[B_INT_STAT] == $past(intx_assert))
    else $error("interrupt status wrong");
  // Leaving reset, every command bit and the parity flag read clear
  a_cmd_reset: assert property (@(posedge ref_clk) disable iff (reset) // [R4] [R5] [R6] [R15]
    $fell(reset) |-> (r.cmd == CMD_RESET && !parity_flagged))
    else $error("command not cleared by reset");
  // Each remaining writable command bit follows its write on the next edge
  a_master_write: assert property (@(posedge ref_clk) disable iff (reset) // [R6]
    (r.st == ST_WRITE && cfg_addr == OFF_CMD && cfg_be[0]) |=> master_enable == $past(cfg_wdata[B_MASTER]))
    else $error("master enable not written");
  a_perr_write: assert property (@(posedge ref_clk) disable iff (reset) // [R11]
    (r.st == ST_WRITE && cfg_addr == OFF_CMD && cfg_be[0]) |=> r.cmd[B_PERR] == $past(cfg_wdata[B_PERR]))
    else $error("parity enable not written");
  a_serr_write: assert property (@(posedge ref_clk) disable iff (reset) // [R13]
    (r.st == ST_WRITE && cfg_addr == OFF_CMD && cfg_be[1]) |=> r.cmd[B_SERR] == $past(cfg_wdata[B_SERR]))
    else $error("error report enable not written");
  a_intx_write: assert property (@(posedge ref_clk) disable iff (reset) // [R15]
    (r.st == ST_WRITE && cfg_addr == OFF_CMD && cfg_be[1]) |=> r.cmd[B_INTX_DIS] == $past(cfg_wdata[B_INTX_DIS]))
    else $error("interrupt disable not written");
  // An enabled fatal event gives one report, of the kind the bridge direction asks for
  a_err_fwd: assert property (@(posedge ref_clk) disable iff (reset) // [R13]
    (fatal_event && r.cmd[B_SERR] && !reverse_mode) |=> (err_message && !serr_n_oe))
    else $error("error message missing");
  a_err_rev: assert property (@(posedge ref_clk) disable iff (reset) // [R13]
    (fatal_event && r.cmd[B_SERR] && reverse_mode) |=> (serr_n_oe && !serr_n_out && !err_message))
    else $error("system error pin not pulled");
  // Writing one clears the parity flag when no new error lands in the same cycle
  a_mdpe_clear: assert property (@(posedge ref_clk) disable iff (reset) // [R11]
    (r.st == ST_WRITE && cfg_addr == OFF_CMD && cfg_be[3] && cfg_wdata[B_MDPE] && !parity_event)
    |=> !parity_flagged) else $error("parity flag not cleared");
  // The sticky word must ride through an ordinary reset; no disable here on purpose
  a_sticky_keep: assert property (@(posedge ref_clk) // [R1]
    (reset && !sticky_reset && !sticky_wr && sticky_val[0]) |=> sticky_val[0])
    else $error("sticky bit lost in reset");
  // Covers for the main scenarios
  c_cmd_write: cover property (@(posedge ref_clk) r.st == ST_WRITE && cfg_addr == OFF_CMD);
  c_parity: cover property (@(posedge ref_clk) $rose(parity_flagged));
  c_serr: cover property (@(posedge ref_clk) serr_n_oe);
  c_split: cover property (@(posedge ref_clk) split_allowed && !master_enable);
  c_intx_gate: cover property (@(posedge ref_clk) intx_request && r.cmd[B_INTX_DIS]);
endmodule : ncc_command
`default_nettype wire

// File: ncc_host.sv
// Host model that issues configuration cycles to the command block.
`default_nettype none
module ncc_host (
  input wire logic ref_clk,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end
  // One access, held until the ack edge; on release the strobes drop and address, byte enables and data are inverted so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
      output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge ref_clk);
    cfg_wr <= w;
    cfg_rd <= ~w;
    cfg_addr <= a;
    cfg_be <= b;
    cfg_wdata <= d;
    while (n < 8 && !ok) begin
      @(negedge ref_clk);
      ok = (cfg_ack === 1'b1);
      n++;
    end
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    cfg_addr <= ~a;
    cfg_be <= ~b;
    cfg_wdata <= ~d;
    @(negedge ref_clk);
    q = cfg_rdata;
  endtask : xfer
endmodule : ncc_host
`default_nettype wire

// File: ncc_command_bench.sv
// Self-checking bench for the primary configuration command block.
`default_nettype none
module ncc_command_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ncc_pkg::*;
  localparam logic [15:0] MK = 16'h5A5A; // Arbitrary identity value
  localparam logic [15:0] PT = 16'hC3C3; // Arbitrary identity value
  logic ref_clk, reset, sticky_reset, reverse_mode, pcix_primary, intx_request, parity_event, fatal_event;
  logic split_completion_req, cfg_rd, cfg_wr, cfg_ack, io_enable, mem_enable, master_enable, split_allowed;
  logic err_message, serr_n_out, serr_n_oe, intx_assert, parity_flagged;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, q;
  int n_fail, n_tests;
  ncc_command #(.MAKER_CODE(MK), .PART_CODE(PT)) ncc_command_i (.ref_clk(ref_clk), .reset(reset),
    .sticky_reset(sticky_reset), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .reverse_mode(reverse_mode),
    .pcix_primary(pcix_primary), .intx_request(intx_request), .parity_event(parity_event),
    .fatal_event(fatal_event), .split_completion_req(split_completion_req), .io_enable(io_enable),
    .mem_enable(mem_enable), .master_enable(master_enable), .split_allowed(split_allowed),
    .err_message(err_message), .serr_n_out(serr_n_out), .serr_n_oe(serr_n_oe), .intx_assert(intx_assert),
    .parity_flagged(parity_flagged));
  ncc_host ncc_host_i (.ref_clk(ref_clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    logic ok;
    ncc_host_i.xfer(1'b1, a, b, d, q, ok);
    chk("write ack", 32'h1, ok);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic ok;
    ncc_host_i.xfer(1'b0, a, 4'hF, 32'h0000_0000, q, ok);
    chk("read ack", 32'h1, ok);
    chk("read data", e, q);
  endtask : rd
  // Reset for eight cycles; s also clears the sticky word
  task automatic rst(input logic s);
    @(posedge ref_clk);
    reset <= 1'b1;
    sticky_reset <= s;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    sticky_reset <= 1'b0;
  endtask : rst
  // One-cycle error pulse; returns in the cycle after it was taken
  task automatic ev(input logic f);
    @(posedge ref_clk);
    fatal_event <= f;
    parity_event <= ~f;
    @(posedge ref_clk);
    fatal_event <= 1'b0;
    parity_event <= 1'b0;
    @(negedge ref_clk);
  endtask : ev
  task automatic end_sim;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_cmd;
    rd(OFF_ID, {PT, MK});
    rd(8'h80, 32'h0000_0000);
    rd(OFF_CMD, 32'h0000_0000);
    wr(OFF_CMD, 4'hF, 32'hFFFF_FBFF);
    rd(OFF_CMD, {16'h0000, CMD_WMASK & 16'hFBFF});
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CMD, 4'h3, 32'h1 << i);
      chk("enables", 32'h1 << i, {master_enable, mem_enable, io_enable});
    end
  endtask : t_cmd
  // Split completions may bypass mastering only for a reverse bridge on PCI-X
  task automatic t_split;
    @(posedge ref_clk);
    split_completion_req <= 1'b1;
    @(negedge ref_clk);
    chk("split master", 32'h1, split_allowed);
    wr(OFF_CMD, 4'h3, 32'h0000_0000);
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk);
      {reverse_mode, pcix_primary} <= m[1:0];
      @(negedge ref_clk);
      chk("split mode", 32'(m == 3), split_allowed);
    end
    // Back to a forward bridge with no split pending, as later scenarios expect
    @(posedge ref_clk);
    {reverse_mode, pcix_primary, split_completion_req} <= 3'b000;
    @(negedge ref_clk);
    chk("split idle", 32'h0, split_allowed);
  endtask : t_split
  task automatic t_intx;
    @(posedge ref_clk);
    intx_request <= 1'b1;
    rd(OFF_CMD, 32'h0008_0000);
    chk("intx on", 32'h1, intx_assert);
    wr(OFF_CMD, 4'h3, 32'h0000_0400);
    chk("intx off", 32'h0, intx_assert);
    rd(OFF_CMD, 32'h0000_0400);
    // Drop the request so later status reads see no pending interrupt
    @(posedge ref_clk);
    intx_request <= 1'b0;
  endtask : t_intx
  // Error reporting gated by bits 6 and 8; the sticky word must outlive an ordinary reset
  task automatic t_err;
    wr(OFF_CMD, 4'h3, 32'h0000_0000);
    ev(1'b0);
    chk("parity off", 32'h0, parity_flagged);
    ev(1'b1);
    chk("fatal off", 32'h0, {err_message, serr_n_oe});
    wr(OFF_CMD, 4'h3, 32'h0000_0140);
    ev(1'b0);
    rd(OFF_CMD, 32'h0100_0140);
    wr(OFF_CMD, 4'h8, 32'h0100_0000);
    rd(OFF_CMD, 32'h0000_0140);
    ev(1'b1);
    chk("err message", 32'h2, {err_message, serr_n_oe});
    @(negedge ref_clk);
    chk("err pulse end", 32'h0, {err_message, serr_n_oe});
    @(posedge ref_clk);
    reverse_mode <= 1'b1;
    ev(1'b1);
    chk("serr pin", 32'h2, {err_message, serr_n_oe, serr_n_out});
    rst(1'b0);
    rd(OFF_STICKY, 32'h0000_0001);
    rd(OFF_CMD, 32'h0000_0000);
    rst(1'b1);
    rd(OFF_STICKY, 32'h0000_0000);
  endtask : t_err
  // Clock, watchdog and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #200us;
    n_fail++;
    end_sim();
  end
  initial begin
    {reset, sticky_reset, reverse_mode, pcix_primary, intx_request} = 5'b11000;
    {parity_event, fatal_event, split_completion_req, n_fail, n_tests} = '0;
    rst(1'b1);
    t_cmd();
    t_split();
    t_intx();
    t_err();
    end_sim();
  end
endmodule : ncc_command_bench
`default_nettype wire
